// [hw/nas_alu.sv]
/*
  Four-bit add/subtract datapath with its own 64-nibble data memory,
  carry/borrow flag, skip flag and program counter.
  Assumes instructions come from fetch logic on the same clock, one per
  cycle at most, qualified by instr_valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nas_defs.svh"

module nas_alu #(
  parameter int PC_W = 13
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              instr_valid,
  input  wire nas_pkg::nas_instr_t instr,
  input  wire nas_pkg::nas_addr_t  rd_addr,
  output var  nas_pkg::nas_nib_t   rd_data,
  output var  logic [PC_W-1:0]   pc,
  output var  logic              carry,
  output var  logic              skip_pending
);
  import nas_pkg::*;

  logic       rst_meta_b;
  logic       rst_sync_b;
  nas_nib_t   mem [64];
  nas_act_t   act;
  logic       arith;
  logic       is_sub;
  logic       is_imm;
  logic       use_c;
  logic       can_skip;
  nas_addr_t  mem_addr;
  nas_addr_t  reg_addr;
  nas_nib_t   mem_val;
  nas_nib_t   opa;
  nas_nib_t   opb;
  logic [4:0] res;
  logic       wr_en;
  nas_addr_t  wr_addr;
  logic [PC_W-1:0] next_pc;
  logic       next_carry;
  logic       next_skip;
  nas_nib_t   next_rd_data;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Decode
  always_comb begin
    arith    = instr[`NAS_GRP_HI:`NAS_GRP_LO] == `NAS_GRP_ARITH;
    is_sub   = instr[`NAS_BIT_SUB];
    is_imm   = instr[`NAS_BIT_IMM];
    use_c    = instr[`NAS_BIT_CARRY];
    can_skip = instr[`NAS_BIT_SKIP];
    mem_addr = {instr[`NAS_ROW_HI:`NAS_ROW_LO],
                instr[`NAS_COL_HI:`NAS_COL_LO]};
    reg_addr = {`NAS_BANK0_ROW, instr[`NAS_OPD_HI:`NAS_OPD_LO]};
    if (!instr_valid)
      act = NAS_IDLE;
    else if (skip_pending)
      act = NAS_SKIP;
    else
      act = NAS_EXEC;
  end

  // Operands and result
  always_comb begin
    mem_val = mem[mem_addr];
    if (is_imm) begin
      opa = mem_val;
      opb = instr[`NAS_OPD_HI:`NAS_OPD_LO];
    end else begin
      opa = mem[reg_addr];
      opb = mem_val;
    end
    if (is_sub)
      res = {1'b0, opa} - {1'b0, opb} - {4'h0, use_c & carry};
    else
      res = {1'b0, opa} + {1'b0, opb} + {4'h0, use_c & carry};
    wr_en   = (act == NAS_EXEC) && arith;
    wr_addr = is_imm ? mem_addr : reg_addr;
  end

  // Next control state
  always_comb begin
    next_pc      = pc;
    next_carry   = carry;
    next_skip    = skip_pending;
    next_rd_data = mem[rd_addr];
    case (act)
      NAS_IDLE: begin
      end
      NAS_SKIP: begin
        next_pc   = pc + 1'b1;
        next_skip = 1'b0;
      end
      NAS_EXEC: begin
        next_pc = pc + 1'b1;
        if (arith) begin
          next_carry = res[4];
          next_skip  = can_skip & res[4];
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pc           <= PC_W'(`NAS_RST_PC);
      carry        <= `NAS_RST_CARRY;
      skip_pending <= 1'b0;
      rd_data      <= 4'h0;
    end else begin
      pc           <= next_pc;
      carry        <= next_carry;
      skip_pending <= next_skip;
      rd_data      <= next_rd_data;
    end
  end

  // Data memory cleared while reset is held, so operands start known
  always_ff @(posedge clk) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 4'h0;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= res[3:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_exec_skip_arith;
    instr_valid && !skip_pending && arith && can_skip;
  endsequence

  sequence s_skip_slot;
    skip_pending && instr_valid;
  endsequence

  property p_row;
    wr_en && is_imm |=>
      mem[{$past(instr[9:8]), $past(instr[7:4])}] == $past(res[3:0]);
  endproperty
  a_row: assert property (p_row)
    else $error("row address not from bits 9:8");

  property p_col;
    wr_en && !is_imm |-> opb == mem[{instr[9:8], instr[7:4]}];
  endproperty
  a_col: assert property (p_col)
    else $error("column address not from bits 7:4");

  property p_reg;
    wr_en && !is_imm |=>
      mem[{2'h0, $past(instr[3:0])}] == $past(res[3:0]);
  endproperty
  a_reg: assert property (p_reg)
    else $error("register target not in bank 0");

  property p_imm_add;
    wr_en && is_imm && !is_sub && !use_c |->
      res[3:0] == 4'(mem[mem_addr] + instr[3:0]);
  endproperty
  a_imm_add: assert property (p_imm_add)
    else $error("immediate add wrong");

  property p_reg_add_wb;
    nas_addr_t a;
    nas_nib_t  v;
    (wr_en && !is_imm && !is_sub, a = reg_addr,
     v = 4'(mem[reg_addr] + mem[mem_addr] + (use_c & carry)))
      |=> mem[a] == v;
  endproperty
  a_reg_add_wb: assert property (p_reg_add_wb)
    else $error("register add not written back");

  property p_add_skip;
    s_exec_skip_arith ##0 (!is_sub && res[4]) |=> skip_pending;
  endproperty
  a_add_skip: assert property (p_add_skip)
    else $error("add with carry did not skip");

  property p_imm_wb;
    nas_addr_t a;
    nas_nib_t  v;
    (wr_en && is_imm, a = mem_addr, v = res[3:0]) |=> mem[a] == v;
  endproperty
  a_imm_wb: assert property (p_imm_wb)
    else $error("memory result not stored");

  property p_sub_val;
    wr_en && is_sub && !use_c |->
      res[3:0] == 4'(opa - opb) && res[4] == (opa < opb);
  endproperty
  a_sub_val: assert property (p_sub_val)
    else $error("subtract result or borrow wrong");

  property p_sub_skip;
    s_exec_skip_arith ##0 (is_sub && opa < opb) |=> skip_pending;
  endproperty
  a_sub_skip: assert property (p_sub_skip)
    else $error("subtract with borrow did not skip");

  property p_no_skip;
    instr_valid && !skip_pending && arith && !can_skip |=> !skip_pending;
  endproperty
  a_no_skip: assert property (p_no_skip)
    else $error("non-skip opcode requested skip");

  property p_flag;
    wr_en |=> carry == $past(res[4]);
  endproperty
  a_flag: assert property (p_flag)
    else $error("carry flag not updated");

  property p_skipped;
    s_skip_slot |-> !wr_en ##1 (!skip_pending && pc == $past(pc) + 1'b1
                                && carry == $past(carry));
  endproperty
  a_skipped: assert property (p_skipped)
    else $error("skipped instruction changed state");
endmodule
`default_nettype wire

// [inc/nas_defs.svh]
/*
  Constants for the nibble add/subtract datapath: instruction field
  positions and reset values. Assumes inclusion by bare name.
*/
`ifndef NAS_DEFS_SVH
`define NAS_DEFS_SVH

`define NAS_GRP_HI      15
`define NAS_GRP_LO      14
`define NAS_BIT_SUB     13
`define NAS_BIT_IMM     12
`define NAS_BIT_CARRY   11
`define NAS_BIT_SKIP    10
`define NAS_ROW_HI      9
`define NAS_ROW_LO      8
`define NAS_COL_HI      7
`define NAS_COL_LO      4
`define NAS_OPD_HI      3
`define NAS_OPD_LO      0
`define NAS_GRP_ARITH   2'h1
`define NAS_BANK0_ROW   2'h0
`define NAS_RST_PC      13'h0000
`define NAS_RST_CARRY   1'h0

`endif

// [inc/nas_pkg.sv]
/*
  Types for the nibble add/subtract datapath.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nas_pkg;
  typedef logic [3:0]  nas_nib_t;
  typedef logic [5:0]  nas_addr_t;
  typedef logic [15:0] nas_instr_t;
  typedef enum logic [1:0] {
    NAS_IDLE,
    NAS_EXEC,
    NAS_SKIP
  } nas_act_t;
endpackage

// [tb/nas_alu_bench.sv]
/*
  Self-checking bench for the nibble add/subtract datapath.
  Assumes nas_pkg is compiled first; bench models all four rows.
*/
`timescale 1ns/1ps
`default_nettype none
module nas_alu_bench;
  import nas_pkg::*;
  logic        clk = 0;
  logic        rst_b = 0;
  logic        instr_valid = 0;
  nas_instr_t  instr = '0;
  nas_addr_t   rd_addr = '0;
  nas_nib_t    rd_data;
  logic [12:0] pc;
  logic        carry;
  logic        skip_pending;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [14:0] q_st[$];
  nas_nib_t    q_rd[$];
  nas_nib_t    ref_mem[64] = '{default: 4'h0};
  logic [12:0] ref_pc = '0;
  logic        ref_c = 0;
  logic        ref_s = 0;
  logic [5:0]  prev = '0;
  logic [1:0]  row = '0;
  logic        st_v1 = 0;
  logic        armed = 0;
  logic        st_v = 0;
  logic        rd_v = 0;
  logic        rd_v1 = 0;

  always #10 clk = ~clk;

  nas_alu #(.PC_W(13)) dut_u (
    .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .rd_addr(rd_addr), .rd_data(rd_data), .pc(pc), .carry(carry),
    .skip_pending(skip_pending));

  task automatic chk_state(input logic [14:0] e, input logic [14:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD state exp %h got %h", e, g);
    end
  endtask

  task automatic chk_nib(input nas_nib_t e, input nas_nib_t g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD nibble exp %h got %h", e, g);
    end
  endtask

  // Results appear one edge after the request; look once settled
  always @(posedge clk) begin
    st_v1 <= st_v;
    rd_v1 <= rd_v;
  end

  always @(negedge clk) begin
    if (st_v1) chk_state(q_st.pop_front(), {pc, carry, skip_pending});
    if (rd_v1) chk_nib(q_rd.pop_front(), rd_data);
  end

  // Read back the previous target while the next request goes in
  task automatic read_prev;
    rd_addr <= prev;
    rd_v <= armed;
    if (armed) q_rd.push_back(ref_mem[prev]);
    armed = 1;
  endtask

  task automatic issue(input logic [3:0] op, col, opd);
    logic [3:0] a;
    logic [3:0] b;
    logic [4:0] r;
    @(posedge clk);
    instr <= {2'h1, op, row, col, opd};
    instr_valid <= 1'b1;
    st_v <= 1'b1;
    read_prev();
    a = op[2] ? ref_mem[{row, col}] : ref_mem[{2'h0, opd}];
    b = op[2] ? opd : ref_mem[{row, col}];
    r = op[3] ? {1'b0, a} - {1'b0, b} - (op[1] & ref_c)
              : {1'b0, a} + {1'b0, b} + (op[1] & ref_c);
    prev = op[2] ? {row, col} : {2'h0, opd};
    if (ref_s) ref_s = 0;
    else begin
      ref_c = r[4];
      ref_s = op[0] & r[4];
      ref_mem[prev] = r[3:0];
    end
    ref_pc++;
    q_st.push_back({ref_pc, ref_c, ref_s});
  endtask

  // Outside the arithmetic group: only the counter moves and any pending skip clears
  task automatic other(input logic [1:0] grp, input logic [13:0] body);
    @(posedge clk);
    instr <= {grp, body};
    instr_valid <= 1'b1;
    st_v <= 1'b1;
    read_prev();
    ref_s = 0;
    ref_pc++;
    q_st.push_back({ref_pc, ref_c, ref_s});
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      instr_valid <= 1'b0;
      st_v <= 1'b1;
      read_prev();
      q_st.push_back({ref_pc, ref_c, ref_s});
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'hd32d));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk_state(15'h0, {pc, carry, skip_pending});
    $display("reset test done");
    // Register minus itself clears bank 0 and the flag
    for (int c = 0; c < 16; c++) issue(4'h8, c[3:0], c[3:0]);
    idle(2);
    $display("clear test done");
    for (int k = 0; k < 160; k++) begin
      row = 2'($urandom);
      issue(k[3:0], 4'($urandom), 4'($urandom));
      if (k % 23 == 0) idle(1);
      if (k % 17 == 5) other(k[5:4] == 2'h1 ? 2'h2 : k[5:4], 14'($urandom));
    end
    row = 2'h0;
    idle(3);
    $display("random test done");
    // Clear column 3 twice so a pending skip cannot leave it set
    issue(4'h8, 4'h3, 4'h3);
    issue(4'h8, 4'h3, 4'h3);
    // Max nibble plus one carries and skips the next request
    issue(4'h4, 4'h3, 4'hf);
    issue(4'h5, 4'h3, 4'h1);
    issue(4'h4, 4'h3, 4'h7);
    issue(4'hd, 4'h3, 4'h9);
    other(2'h3, 14'h0);
    issue(4'h0, 4'h2, 4'h5);
    idle(3);
    $display("skip test done");
    test_done();
  end
endmodule
`default_nettype wire
